// ===== rtl/ifv_axil.sv
// AXI4-Lite slave that turns bus transfers into register accesses
`timescale 1ns/1ps
`include "ifv_regs.svh"
module ifv_axil (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  ifv_regbus_if.slave rb
);
  ifv_pkg::ifv_axi_t st;
  ifv_pkg::ifv_axi_t next_st;
  logic do_wr;

  // Write fires once address and data are both held
  assign do_wr = st.aw_held & st.w_held & ~st.bvalid;
  assign rb.wr_en = do_wr & st.w_lane0 & ~st.aw_bad;
  assign rb.wr_idx = st.aw_idx;
  assign rb.wr_data = st.w_data;
  assign rb.rd_idx = araddr[9:2];
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

  // Channel bookkeeping; address and data may arrive in either order
  always_comb begin
    next_st = st;
    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = awaddr[9:2];
      next_st.aw_bad = |awaddr[11:10];
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_lane0 = wstrb[0];
    end
    if (do_wr) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      // Unmapped index answers SLVERR, nothing stored
      next_st.bresp = (rb.wr_hit && !st.aw_bad) ? 2'h0 : 2'h2;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready = ~next_st.w_held & ~next_st.bvalid;
    // Read data is captured at the address handshake
    if (arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      if (rb.rd_hit && araddr[11:10] == 2'h0) begin
        next_st.rdata = {24'h000000, rb.rd_data};
        next_st.rresp = 2'h0;
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = 2'h2;
      end
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = ~next_st.rvalid;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ===== rtl/ifv_pkg.sv
// Types shared by the ifv interrupt block
package ifv_pkg;
  typedef enum logic [2:0] {
    IFV_IDLE = 3'b001,
    IFV_SYNC = 3'b010,
    IFV_VECT = 3'b100
  } ifv_seq_t;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_idx;
    logic aw_bad;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ifv_axi_t;

  typedef struct packed {
    logic [7:0] main_ctl;
    logic [7:0] flg_a;
    logic [2:0] flg_b;
    logic [7:0] en_a;
    logic [2:0] en_b;
    logic [7:0] option;
    ifv_seq_t seq;
    logic [1:0] div;
    logic boundary;
    logic primed;
    logic pin_prev;
    logic [7:0] tmr_prev;
    logic [3:0] port_prev;
    logic sleeping;
    logic wake_hold;
    logic pwr_dn;
    logic to;
    logic irq_req;
    logic push;
    logic [12:0] push_pc;
    logic pc_load;
    logic pop;
    logic wake;
  } ifv_st_t;
endpackage

// ===== rtl/ifv_regbus_if.sv
// Internal register access carrier between bus slave and register file
`timescale 1ns/1ps
interface ifv_regbus_if;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  modport slave(output wr_en, wr_idx, wr_data, rd_idx,
                input wr_hit, rd_data, rd_hit);
  modport regs(input wr_en, wr_idx, wr_data, rd_idx,
               output wr_hit, rd_data, rd_hit);
endinterface

// ===== rtl/ifv_regs.svh
// Register indices, bit positions, reset values and timing for ifv
// ----------------------------------------------------------------
// Summary of operation
// - Each source flag sets on its event regardless of any enable.
// - Global enable at main control bit 7 passes or blocks all requests.
// - With global enable set, a flagged and enabled source is taken.
// - Every reset clears the global enable.
// - Return-from-interrupt instruction pops PC and sets global enable.
// - Acceptance clears global enable, pushes return PC, loads 0004h.
// - Pin and port-change latency is three or four instruction cycles.
// - Pin edge is rising when option bit 6 set, else falling.
// - Valid pin edge sets flag bit 1; enable bit 4 gates it.
// - Enabled pin interrupt wakes sleep; global enable decides vectoring.
// - Timer zero rollover FFh to 00h sets flag bit 2; enable bit 5.
// - Upper four port pins changing set flag bit 0; own enable.
// - Peripheral flags and enables in two register pairs, group enable.
// - Only the return PC is saved; other registers left to software.
// - Fourteen sources; small package omits the parallel slave source.
// - Any enabled pending source wakes sleep; vector after next instr.
// - Sleep with a pending enabled source acts as no-operation.
// ----------------------------------------------------------------
`ifndef IFV_REGS_SVH
`define IFV_REGS_SVH
// Register indices; byte address is four times the index
`define IFV_IDX_MAIN 8'h0B
`define IFV_IDX_FLGA 8'h0C
`define IFV_IDX_FLGB 8'h0D
`define IFV_IDX_OPT 8'h81
`define IFV_IDX_ENA 8'h8C
`define IFV_IDX_ENB 8'h8D
`define IFV_IDX_STAT 8'h90
// Main control bit positions, then the option edge bit and the PSP flag bit
`define IFV_B_GLB_EN 7
`define IFV_B_GRP_EN 6
`define IFV_B_TMR_EN 5
`define IFV_B_PIN_EN 4
`define IFV_B_PORT_EN 3
`define IFV_B_TMR_FLG 2
`define IFV_B_PIN_FLG 1
`define IFV_B_PORT_FLG 0
`define IFV_B_EDGE 6
`define IFV_B_PSP 7
// Reset values
`define IFV_RST_MAIN 8'h00
`define IFV_RST_OPT 8'hFF
`define IFV_RST_FLG 8'h00
// Core sequencing constants
`define IFV_VECTOR 13'h0004
`define IFV_TMR_TOP 8'hFF
`define IFV_TMR_ZERO 8'h00
`define IFV_DIV_LAST 2'h3
`define IFV_NPER 11
`define IFV_NA 8
`endif

// ===== rtl/ifv_top.sv
// Interrupt flag, enable and vector logic with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ifv_regs.svh"
module ifv_top #(
  parameter bit HAS_PSP = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Event sources
  input wire logic ext_irq_pin,
  input wire logic [7:0] timer_zero_count,
  input wire logic [3:0] port_b_high,
  input wire logic [10:0] periph_event,
  // Core sequencer and stack
  input wire logic [12:0] core_pc,
  input wire logic return_from_irq_instr,
  input wire logic sleep_instr,
  output logic irq_request,
  output logic stack_push,
  output logic [12:0] stack_push_pc,
  output logic pc_load,
  output logic [12:0] pc_load_addr,
  output logic stack_pop,
  output logic instr_cycle,
  // Power state
  output logic sleeping,
  output logic wake_up,
  output logic power_down_status,
  output logic time_out_status
);
  ifv_pkg::ifv_st_t st;
  ifv_pkg::ifv_st_t next_st;
  ifv_regbus_if rb();
  logic [10:0] per_set;
  logic [10:0] per_pend;
  logic [10:0] per_flg;
  logic [10:0] per_en;
  logic q_en;
  logic pin_edge;
  logic pin_raw;
  logic tmr_roll;
  logic port_chg;
  logic core_any;
  logic per_any;
  logic wake_cond;
  logic take;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  ifv_axil u_axil (
    .clk(clk),
    .nrst(nrst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rb(rb)
  );

  // ----------------------------------------------------------------
  // Source detection
  // ----------------------------------------------------------------
  // Instruction cycle is four clocks; sequencing advances on q_en
  assign q_en = (st.div == `IFV_DIV_LAST);
  assign per_flg = {st.flg_b, st.flg_a};
  assign per_en = {st.en_b, st.en_a};

  // Peripheral sources; parallel slave source absent on small package
  for (genvar i = 0; i < `IFV_NPER; i++) begin : g_per
    if (i == `IFV_B_PSP) begin : g_psp
      assign per_set[i] = periph_event[i] & HAS_PSP;
    end else begin : g_std
      assign per_set[i] = periph_event[i];
    end
    assign per_pend[i] = per_flg[i] & per_en[i];
  end

  // Edge polarity from the option register
  assign pin_raw = st.option[`IFV_B_EDGE] ?
    (ext_irq_pin & ~st.pin_prev) : (~ext_irq_pin & st.pin_prev);
  // Previous samples reset to constants, not pin levels; until one real
  // sample is held a pin that idles high would look like an edge
  assign pin_edge = pin_raw & st.primed;
  assign tmr_roll = (st.tmr_prev == `IFV_TMR_TOP) &&
    (timer_zero_count == `IFV_TMR_ZERO);
  // Any difference against last sample counts as a change; comparing
  // against the last port read would need a read strobe we lack
  assign port_chg = st.primed & (|(port_b_high ^ st.port_prev));

  // Request combine: core pairs direct, peripherals through group enable
  assign core_any =
    (st.main_ctl[`IFV_B_TMR_EN] & st.main_ctl[`IFV_B_TMR_FLG]) |
    (st.main_ctl[`IFV_B_PIN_EN] & st.main_ctl[`IFV_B_PIN_FLG]) |
    (st.main_ctl[`IFV_B_PORT_EN] & st.main_ctl[`IFV_B_PORT_FLG]);
  // Peripheral pairs count only through the group enable bit
  assign per_any = st.main_ctl[`IFV_B_GRP_EN] & (|per_pend);
  // Wake-up ignores the global enable
  assign wake_cond = core_any | per_any;
  // Acceptance needs the global enable and the core awake; the wake hold
  // lets the instruction after sleep run before the vector is taken
  assign take = st.main_ctl[`IFV_B_GLB_EN] & wake_cond & ~st.sleeping &
    ~st.wake_hold;

  // ----------------------------------------------------------------
  // Register read and write decode
  // ----------------------------------------------------------------
  // Read data by index; unknown indices answer with a miss
  always_comb begin
    rb.rd_hit = 1'b1;
    case (rb.rd_idx)
      `IFV_IDX_MAIN: rb.rd_data = st.main_ctl;
      `IFV_IDX_FLGA: rb.rd_data = st.flg_a;
      `IFV_IDX_FLGB: rb.rd_data = {5'h00, st.flg_b};
      `IFV_IDX_OPT: rb.rd_data = st.option;
      `IFV_IDX_ENA: rb.rd_data = st.en_a;
      `IFV_IDX_ENB: rb.rd_data = {5'h00, st.en_b};
      `IFV_IDX_STAT: rb.rd_data = {5'h00, st.sleeping, st.to, st.pwr_dn};
      default: begin
        rb.rd_data = 8'h00;
        rb.rd_hit = 1'b0;
      end
    endcase
  end

  // Status index is read only; writes there are refused
  always_comb begin
    case (rb.wr_idx)
      `IFV_IDX_MAIN, `IFV_IDX_FLGA, `IFV_IDX_FLGB, `IFV_IDX_OPT,
      `IFV_IDX_ENA, `IFV_IDX_ENB: rb.wr_hit = 1'b1;
      default: rb.wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.div = st.div + 2'h1;
    next_st.pin_prev = ext_irq_pin;
    next_st.tmr_prev = timer_zero_count;
    next_st.port_prev = port_b_high;
    // Samples above are real from the first clock out of reset on
    next_st.primed = 1'b1;
    // Boundary is registered so the output comes from a flop
    next_st.boundary = (next_st.div == `IFV_DIV_LAST);
    next_st.push = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.pop = 1'b0;
    next_st.wake = 1'b0;

    // Software writes first, so hardware sets below win a same-cycle clear
    if (rb.wr_en) begin
      case (rb.wr_idx)
        `IFV_IDX_MAIN: next_st.main_ctl = rb.wr_data;
        `IFV_IDX_FLGA: next_st.flg_a = rb.wr_data;
        `IFV_IDX_FLGB: next_st.flg_b = rb.wr_data[2:0];
        `IFV_IDX_OPT: next_st.option = rb.wr_data;
        `IFV_IDX_ENA: next_st.en_a = rb.wr_data;
        `IFV_IDX_ENB: next_st.en_b = rb.wr_data[2:0];
        default: next_st.option = st.option;
      endcase
    end

    // Flags set whatever the enables say
    if (pin_edge) begin
      next_st.main_ctl[`IFV_B_PIN_FLG] = 1'b1;
    end
    if (tmr_roll) begin
      next_st.main_ctl[`IFV_B_TMR_FLG] = 1'b1;
    end
    if (port_chg) begin
      next_st.main_ctl[`IFV_B_PORT_FLG] = 1'b1;
    end
    next_st.flg_a = next_st.flg_a | per_set[7:0];
    next_st.flg_b = next_st.flg_b | per_set[10:8];
    // Small package has no parallel slave source, so its bits read zero
    if (!HAS_PSP) begin
      next_st.flg_a[`IFV_B_PSP] = 1'b0;
      next_st.en_a[`IFV_B_PSP] = 1'b0;
    end

    // Return instruction re-enables; the core pops its own stack
    if (return_from_irq_instr) begin
      next_st.main_ctl[`IFV_B_GLB_EN] = 1'b1;
      next_st.pop = 1'b1;
    end

    // Sleep entry, or no-operation when a source already pends
    if (sleep_instr && !st.sleeping) begin
      // A pending pair turns sleep into a no-operation, status untouched
      if (!wake_cond) begin
        next_st.sleeping = 1'b1;
        next_st.pwr_dn = 1'b0;
        next_st.to = 1'b1;
      end
    end
    // Wake regardless of the global enable; one instruction then runs
    if (st.sleeping && wake_cond) begin
      next_st.sleeping = 1'b0;
      next_st.wake = 1'b1;
      next_st.wake_hold = 1'b1;
    end
    if (q_en && !st.sleeping && st.wake_hold) begin
      next_st.wake_hold = 1'b0;
    end

    // Acceptance sequence: boundary, one dead cycle, then vector
    // Three boundaries from flag to push give three or four cycles
    if (q_en) begin
      case (st.seq)
        ifv_pkg::IFV_IDLE: begin
          if (take) begin
            next_st.seq = ifv_pkg::IFV_SYNC;
          end
        end
        ifv_pkg::IFV_SYNC: begin
          // A request withdrawn meanwhile is dropped
          next_st.seq = take ? ifv_pkg::IFV_VECT : ifv_pkg::IFV_IDLE;
        end
        ifv_pkg::IFV_VECT: begin
          next_st.seq = ifv_pkg::IFV_IDLE;
          // Clearing here wins over a same-cycle return or bus write
          next_st.main_ctl[`IFV_B_GLB_EN] = 1'b0;
          // Only the PC is saved; software keeps the rest
          next_st.push = 1'b1;
          next_st.push_pc = core_pc;
          next_st.pc_load = 1'b1;
        end
        default: next_st.seq = ifv_pkg::IFV_IDLE;
      endcase
    end

    // Registered request line
    next_st.irq_req = next_st.main_ctl[`IFV_B_GLB_EN] & wake_cond;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves the global enable clear and the option all ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.main_ctl <= `IFV_RST_MAIN;
      st.flg_a <= `IFV_RST_FLG;
      st.option <= `IFV_RST_OPT;
      st.seq <= ifv_pkg::IFV_IDLE;
      st.pwr_dn <= 1'b1;
      st.to <= 1'b1;
      st.pin_prev <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All but the constant vector address come straight from the state register
  assign irq_request = st.irq_req;
  assign stack_push = st.push;
  assign stack_push_pc = st.push_pc;
  assign pc_load = st.pc_load;
  assign pc_load_addr = `IFV_VECTOR;
  assign stack_pop = st.pop;
  // Same timing as q_en, taken from its registered copy
  assign instr_cycle = st.boundary;
  assign sleeping = st.sleeping;
  assign wake_up = st.wake;
  assign power_down_status = st.pwr_dn;
  assign time_out_status = st.to;
endmodule

// ===== test/ifv_assertions.sv
// Concurrent checks on the ports of the interrupt vector block
`timescale 1ns/1ps
module ifv_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Core side
  input wire logic irq_request,
  input wire logic stack_push,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_addr,
  input wire logic stack_pop,
  input wire logic return_from_irq_instr,
  input wire logic instr_cycle,
  // Power state
  input wire logic sleeping,
  input wire logic wake_up,
  input wire logic power_down_status,
  input wire logic time_out_status
);
  // ----------------------------------------------------------------
  // Sequencing and power checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Boundaries come every fourth clock, which fixes the latency grid
  sequence gap_s; !instr_cycle [*3] ##1 instr_cycle; endsequence
  sequence vec_s; pc_load && pc_load_addr == 13'h0004; endsequence
  instr_period_a:
    assert property (instr_cycle |=> gap_s)
    else $error("boundary spacing off");
  vector_load_a:
    assert property (stack_push |-> vec_s)
    else $error("push without vector load");
  load_with_push_a:
    assert property (pc_load |-> stack_push)
    else $error("vector load without push");
  push_single_a:
    assert property (stack_push |=> !stack_push)
    else $error("push longer than one cycle");
  accept_drops_req_a:
    assert property (stack_push |=> !irq_request)
    else $error("request stays after acceptance");
  push_needs_req_a:
    assert property (stack_push |-> $past(irq_request))
    else $error("push without a request");
  pop_on_return_a:
    assert property (return_from_irq_instr |=> stack_pop)
    else $error("return without pop");
  pop_cause_a:
    assert property (stack_pop |-> $past(return_from_irq_instr))
    else $error("pop without return");
  sleep_status_a:
    assert property ($rose(sleeping) |-> !power_down_status && time_out_status)
    else $error("status wrong on sleep entry");
  wake_clean_a:
    assert property (wake_up |-> !sleeping && $past(sleeping))
    else $error("wake pulse out of place");
  no_vector_asleep_a:
    assert property (stack_push |-> !sleeping)
    else $error("vector taken while asleep");
endmodule

bind ifv_top ifv_assertions u_ifv_assertions (.clk, .nrst, .irq_request,
  .stack_push, .pc_load, .pc_load_addr, .stack_pop, .return_from_irq_instr,
  .instr_cycle, .sleeping, .wake_up, .power_down_status, .time_out_status);

// ===== test/ifv_core_model.sv
// Behavioural model of the core sequencer, program counter and stack
`timescale 1ns/1ps
module ifv_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // From the interrupt block
  input wire logic instr_cycle,
  input wire logic stack_push,
  input wire logic [12:0] stack_push_pc,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_addr,
  input wire logic stack_pop,
  // Bench command and core outputs
  input wire logic ret_req,
  output logic [12:0] core_pc,
  output logic return_from_irq_instr
);
  // ----------------------------------------------------------------
  // Eight-deep stack, wraps like the real one on overflow
  // ----------------------------------------------------------------
  logic [12:0] stk [0:7];
  logic [2:0] sp;
  // Counter steps once per instruction; a vector load wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_pc <= 13'h0000;
      sp <= 3'h0;
      return_from_irq_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= ret_req;
      if (pc_load) begin
        core_pc <= pc_load_addr;
      end else if (stack_pop) begin
        core_pc <= stk[sp - 3'h1];
      end else if (instr_cycle) begin
        core_pc <= core_pc + 13'h0001;
      end
      // Only the return address is kept; other state is software's job
      if (stack_push) begin
        stk[sp] <= stack_push_pc;
        sp <= sp + 3'h1;
      end else if (stack_pop) begin
        sp <= sp - 3'h1;
      end
    end
  end
endmodule

// ===== test/ifv_top_test.sv
// Self-checking bench for the interrupt flag and vector block
`timescale 1ns/1ps
`include "ifv_regs.svh"
module ifv_top_test;
  // ----------------------------------------------------------------
  // Signals, instances and shared tasks
  // ----------------------------------------------------------------
  logic clk, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, ext_irq_pin = 0, sleep_instr = 0, ret_req = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 4'hF, port_b_high = 0;
  logic [7:0] timer_zero_count = 0;
  logic [10:0] periph_event = 0;
  logic [1:0] bresp, rresp, rr;
  logic awready, wready, bvalid, arready, rvalid, return_from_irq_instr;
  logic [12:0] core_pc, stack_push_pc, pc_load_addr, last_pc = 0;
  logic irq_request, stack_push, pc_load, stack_pop, instr_cycle;
  logic sleeping, wake_up, power_down_status, time_out_status;
  int mismatches = 0, comparisons = 0, cyc = 0, pushes = 0, pops = 0;
  int n, k, sel, dir, seed = 3;
  ifv_top u_ifv_top (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ext_irq_pin,
    .timer_zero_count, .port_b_high, .periph_event, .core_pc,
    .return_from_irq_instr, .sleep_instr, .irq_request, .stack_push,
    .stack_push_pc, .pc_load, .pc_load_addr, .stack_pop, .instr_cycle,
    .sleeping, .wake_up, .power_down_status, .time_out_status);
  ifv_core_model u_ifv_core_model (.clk, .nrst, .instr_cycle, .stack_push,
    .stack_push_pc, .pc_load, .pc_load_addr, .stack_pop, .ret_req,
    .core_pc, .return_from_irq_instr);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Event counters and the hang limit, far above the few hundred needed
  always @(posedge clk) begin
    cyc++;
    if (stack_push === 1'b1) begin
      pushes++;
      chk({19'h0, stack_push_pc}, {19'h0, last_pc});
    end
    if (stack_pop === 1'b1) pops++;
    // Counter as the last boundary saw it is the address to be saved
    if (instr_cycle === 1'b1) last_pc = core_pc;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Bus write: both channels offered together, each dropped once taken;
  // only the cycle limit above ends a wait for the answer
  task axw(input logic [7:0] i, input logic [7:0] d);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task axr(input logic [7:0] i);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Edge select 1 hits a rise (dir 0), select 0 hits a fall (dir 1)
  function logic [31:0] pin_exp(input int s, input int d);
    return (s != d) ? 32'h2 : 32'h0;
  endfunction
  function logic [31:0] flag_exp(input int b);
    return 32'h1 << (b % 8);
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    idle(2);
    axr(`IFV_IDX_MAIN);
    chk(rd, 32'h0);
    axr(`IFV_IDX_OPT);
    chk(rd, 32'hFF);
    axr(`IFV_IDX_STAT);
    chk(rd, 32'h3);
    axr(8'h00);
    chk({30'h0, rr}, 32'h2);
    axw(`IFV_IDX_STAT, 8'hFF);
    chk({30'h0, rr}, 32'h2);
    // Pin edges in all four select and direction pairs, enables off
    for (sel = 0; sel < 2; sel++) begin
      for (dir = 0; dir < 2; dir++) begin
        axw(`IFV_IDX_OPT, (sel == 1) ? 8'hFF : 8'hBF);
        ext_irq_pin <= dir[0];
        idle(3);
        axw(`IFV_IDX_MAIN, 8'h00);
        ext_irq_pin <= ~dir[0];
        idle(3);
        axr(`IFV_IDX_MAIN);
        chk(rd & 32'h2, pin_exp(sel, dir));
      end
    end
    // Random counts never reaching a wrap, then the wrap itself
    repeat (4) begin
      timer_zero_count <= 8'h01 + 8'($unsigned($random(seed)) % 254);
      idle(1);
    end
    axr(`IFV_IDX_MAIN);
    chk(rd & 32'h4, 32'h0);
    timer_zero_count <= 8'hFF;
    idle(1);
    timer_zero_count <= 8'h00;
    idle(3);
    axr(`IFV_IDX_MAIN);
    chk(rd & 32'h4, 32'h4);
    axw(`IFV_IDX_MAIN, 8'h00);
    port_b_high <= port_b_high ^ (4'h1 << ($unsigned($random(seed)) % 4));
    idle(3);
    axr(`IFV_IDX_MAIN);
    chk(rd & 32'h1, 32'h1);
    // Random peripheral events land in the matching flag register
    repeat (3) begin
      axw(`IFV_IDX_FLGA, 8'h00);
      axw(`IFV_IDX_FLGB, 8'h00);
      n = $unsigned($random(seed)) % 11;
      periph_event <= 11'h1 << n;
      idle(1);
      periph_event <= 11'h0;
      idle(2);
      axr((n < 8) ? `IFV_IDX_FLGA : `IFV_IDX_FLGB);
      chk(rd, flag_exp(n));
    end
    // Group enable gates peripherals even with global enable set
    axw(`IFV_IDX_ENA, 8'hFF);
    axw(`IFV_IDX_ENB, 8'h07);
    axw(`IFV_IDX_MAIN, 8'h80);
    idle(8);
    chk(pushes, 0);
    chk({31'h0, irq_request}, 32'h0);
    axw(`IFV_IDX_MAIN, 8'hC0);
    chk({31'h0, irq_request}, 32'h1);
    idle(24);
    chk(pushes, 1);
    chk(pc_load_addr, 32'h4);
    axr(`IFV_IDX_MAIN);
    chk(rd & 32'h80, 32'h0);
    axw(`IFV_IDX_FLGA, 8'h00);
    axw(`IFV_IDX_FLGB, 8'h00);
    ret_req <= 1'b1;
    idle(1);
    ret_req <= 1'b0;
    idle(4);
    chk(pops, 1);
    axr(`IFV_IDX_MAIN);
    chk(rd & 32'h80, 32'h80);
    idle(20);
    chk(pushes, 1);
    axw(`IFV_IDX_ENA, 8'h00);
    axw(`IFV_IDX_ENB, 8'h00);
    // Pin latency in boundaries from the edge to the push
    axw(`IFV_IDX_MAIN, 8'h90);
    idle(6);
    ext_irq_pin <= 1'b1;
    n = 0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (instr_cycle === 1'b1) n++;
    end while (stack_push !== 1'b1 && k < 60);
    chk({31'h0, (n >= 3 && n <= 4)}, 32'h1);
    // Sleep, then wake on the pin with the global enable clear
    axw(`IFV_IDX_MAIN, 8'h10);
    ext_irq_pin <= 1'b0;
    sleep_instr <= 1'b1;
    idle(1);
    sleep_instr <= 1'b0;
    idle(2);
    axr(`IFV_IDX_STAT);
    chk(rd, 32'h6);
    ext_irq_pin <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wake_up !== 1'b1 && k < 40);
    chk({31'h0, wake_up}, 32'h1);
    idle(20);
    chk({31'h0, sleeping}, 32'h0);
    chk(pushes, 2);
    // Pending enabled flag turns the next sleep into a no-operation
    sleep_instr <= 1'b1;
    idle(1);
    sleep_instr <= 1'b0;
    idle(3);
    axr(`IFV_IDX_STAT);
    chk(rd, 32'h2);
    conclude();
  end
endmodule
